// ==== src/boot_mode_pkg.sv ====
package boot_mode_pkg;

  // ----------------------------------------------------------------
  // converter and strap bands, in millivolts
  // ----------------------------------------------------------------
  localparam int         MV_W          = 10;
  localparam logic [9:0] MV_EDGE_P0_P3 = 10'd640;
  localparam logic [9:0] MV_EDGE_P3_P4 = 10'd495;
  localparam logic [9:0] MV_EDGE_P4_P5 = 10'd355;
  localparam logic [9:0] MV_EDGE_P5_P6 = 10'd215;
  localparam logic [9:0] MV_EDGE_P6_P7 = 10'd75;

  localparam logic [2:0] PRESET_0 = 3'h0;
  localparam logic [2:0] PRESET_3 = 3'h3;
  localparam logic [2:0] PRESET_4 = 3'h4;
  localparam logic [2:0] PRESET_5 = 3'h5;
  localparam logic [2:0] PRESET_6 = 3'h6;
  localparam logic [2:0] PRESET_7 = 3'h7;

  // converter channel order during boot
  localparam logic [1:0] SEL_BOOT  = 2'h0;
  localparam logic [1:0] SEL_CLOCK = 2'h1;
  localparam logic [1:0] SEL_CHAN  = 2'h2;
  localparam logic [1:0] SEL_MIX   = 2'h3;

  // ----------------------------------------------------------------
  // modes, commands, channel contents
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_ACTIVE  = 2'h0;
  localparam logic [1:0] MODE_BYPASS  = 2'h1;
  localparam logic [1:0] MODE_SLEEP   = 2'h2;
  localparam logic [1:0] MODE_STANDBY = 2'h3;

  localparam logic [1:0] CMD_ACTIVE = 2'h0;
  localparam logic [1:0] CMD_BYPASS = 2'h1;
  localparam logic [1:0] CMD_SLEEP  = 2'h2;

  localparam logic [1:0] SRC_START = 2'h0;
  localparam logic [1:0] SRC_MIXED = 2'h1;
  localparam logic [1:0] SRC_END   = 2'h2;
  localparam logic [1:0] SRC_OFF   = 2'h3;

  typedef enum logic [2:0] {
    ST_RESET   = 3'h0,
    ST_CONV    = 3'h1,
    ST_ACTIVE  = 3'h3,
    ST_BYPASS  = 3'h2,
    ST_SLEEP   = 3'h6,
    ST_STANDBY = 3'h7,
    ST_EXTBOOT = 3'h5
  } state_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int CLK_LOSS_NS    = 10000;
  localparam int CLK_LOSS_CYC   = (CLK_LOSS_NS * 1000) / CLK_PERIOD_PS;
  localparam int STANDBY_MS     = 1000;
  localparam int STANDBY_CYC    = STANDBY_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int LOSS_W         = 12;

endpackage

// ==== src/boot_config_mode_control.sv ====
`timescale 1ns/1ps
module boot_config_mode_control
  import boot_mode_pkg::*;
#(
  parameter int STANDBY_TIMEOUT_CYC = STANDBY_CYC
)(
  input  wire logic            clk,
  input  wire logic            rstn,
  output logic                 conv_start,
  output logic [1:0]           conv_sel,
  input  wire logic            conv_done,
  input  wire logic [MV_W-1:0] conv_mv,
  input  wire logic            mode_cmd_valid,
  input  wire logic [1:0]      mode_cmd,
  input  wire logic            scl_level,
  input  wire logic            external_clock_input,
  output logic [1:0]           mode,
  output logic                 config_done,
  output logic                 ext_boot,
  output logic                 nr_run,
  output logic                 stats_on,
  output logic                 bypass_route,
  output logic                 tone_on,
  output logic                 analog_on,
  output logic                 lowspeed_osc,
  output logic [9:0]           talk_min_cm,
  output logic [9:0]           talk_max_cm,
  output logic [14:0]          external_clock_input_khz,
  output logic                 int_osc,
  output logic                 out_differential,
  output logic                 dual_outputs,
  output logic [1:0]           ch0_src,
  output logic [1:0]           ch1_src,
  output logic [6:0]           mix_pct
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    state_t            st;
    logic [1:0]        sel;
    logic              start;
    logic [2:0]        boot_p;
    logic [2:0]        clk_p;
    logic [2:0]        chan_p;
    logic [2:0]        mix_p;
    logic              cmd_sleep;
    state_t            resume;
    logic              ext_prev;
    logic              scl_prev;
    logic [LOSS_W-1:0] loss_cnt;
    logic [31:0]       stby_cnt;
    logic [1:0]        mode;
    logic              done;
    logic              ext_boot;
    logic              nr_run;
    logic              stats_on;
    logic              bypass;
    logic              tone;
    logic              analog;
    logic              lowosc;
    logic [9:0]        tmin;
    logic [9:0]        tmax;
    logic [14:0]       khz;
    logic              int_osc;
    logic              diff;
    logic              dual;
    logic [1:0]        ch0;
    logic [1:0]        ch1;
    logic [6:0]        mix;
  } regs_t;

  localparam logic [LOSS_W-1:0] LOSS_LIMIT = LOSS_W'(CLK_LOSS_CYC);

  regs_t s_q;
  regs_t s_d;

  logic ext_edge;
  logic scl_fall;
  logic clk_lost;

  // nearest-band resolution puts each gap edge at its midpoint
  function automatic logic [2:0] band(input logic [MV_W-1:0] mv);
    logic [2:0] p;
    if (mv >= MV_EDGE_P0_P3)      p = PRESET_0;
    else if (mv >= MV_EDGE_P3_P4) p = PRESET_3;
    else if (mv >= MV_EDGE_P4_P5) p = PRESET_4;
    else if (mv >= MV_EDGE_P5_P6) p = PRESET_5;
    else if (mv >= MV_EDGE_P6_P7) p = PRESET_6;
    else                          p = PRESET_7;
    return p;
  endfunction

  assign ext_edge = external_clock_input != s_q.ext_prev;
  assign scl_fall = s_q.scl_prev && !scl_level;
  // internal oscillator preset never counts as a lost clock
  assign clk_lost = (s_q.loss_cnt == LOSS_LIMIT) && (s_q.clk_p != PRESET_7);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d          = s_q;
    s_d.start    = 1'b0;
    s_d.ext_prev = external_clock_input;
    s_d.scl_prev = scl_level;
    if (ext_edge)
    begin
      s_d.loss_cnt = '0;
    end
    else if (s_q.loss_cnt != LOSS_LIMIT)
    begin
      s_d.loss_cnt = s_q.loss_cnt + 1'b1;
    end

    case (s_q.st)
      ST_RESET:
      begin
        s_d.st    = ST_CONV;
        s_d.sel   = SEL_BOOT;
        s_d.start = 1'b1;
      end
      ST_CONV:
      begin
        if (conv_done)
        begin
          case (s_q.sel)
            SEL_BOOT:  s_d.boot_p = band(conv_mv);
            SEL_CLOCK: s_d.clk_p  = band(conv_mv);
            SEL_CHAN:  s_d.chan_p = band(conv_mv);
            default:   s_d.mix_p  = band(conv_mv);
          endcase
          if (s_q.sel == SEL_MIX)
          begin
            // straps are never sampled again after this point
            s_d.done = 1'b1;
            if (s_q.boot_p == PRESET_0)
              s_d.st = ST_EXTBOOT;
            else if (s_q.boot_p == PRESET_6 || s_q.boot_p == PRESET_7)
              s_d.st = ST_BYPASS;
            else
              s_d.st = ST_ACTIVE;
          end
          else
          begin
            s_d.sel   = s_q.sel + 1'b1;
            s_d.start = 1'b1;
          end
        end
      end
      ST_ACTIVE, ST_BYPASS:
      begin
        if (mode_cmd_valid && mode_cmd == CMD_ACTIVE)
          s_d.st = ST_ACTIVE;
        else if (mode_cmd_valid && mode_cmd == CMD_BYPASS)
          s_d.st = ST_BYPASS;
        else if (mode_cmd_valid && mode_cmd == CMD_SLEEP)
        begin
          s_d.st        = ST_SLEEP;
          s_d.cmd_sleep = 1'b1;
        end
        else if (clk_lost)
        begin
          s_d.st        = ST_SLEEP;
          s_d.cmd_sleep = 1'b0;
          s_d.resume    = s_q.st;
        end
      end
      ST_SLEEP:
      begin
        // commands are not decoded while asleep; scl wakes a commanded sleep, a clock edge a clock-loss sleep
        if (s_q.cmd_sleep && scl_fall)
        begin
          s_d.st       = ST_STANDBY;
          s_d.stby_cnt = '0;
        end
        else if (!s_q.cmd_sleep && ext_edge)
          s_d.st = s_q.resume;
      end
      ST_STANDBY:
      begin
        s_d.stby_cnt = s_q.stby_cnt + 1'b1;
        if (mode_cmd_valid && mode_cmd == CMD_ACTIVE)
          s_d.st = ST_ACTIVE;
        else if (mode_cmd_valid && mode_cmd == CMD_BYPASS)
          s_d.st = ST_BYPASS;
        else if ((mode_cmd_valid && mode_cmd == CMD_SLEEP)
                 || s_q.stby_cnt == 32'(STANDBY_TIMEOUT_CYC - 1))
        begin
          s_d.st        = ST_SLEEP;
          s_d.cmd_sleep = 1'b1;
        end
      end
      ST_EXTBOOT:
      begin
        s_d.st = ST_EXTBOOT;
      end
      default:
      begin
        s_d.st = ST_RESET;
      end
    endcase

    // ---------------------------------------------------------------
    // decode, aligned with the next state
    // ---------------------------------------------------------------
    s_d.mode     = (s_d.st == ST_BYPASS)  ? MODE_BYPASS  :
                   (s_d.st == ST_SLEEP)   ? MODE_SLEEP   :
                   (s_d.st == ST_STANDBY) ? MODE_STANDBY : MODE_ACTIVE;
    s_d.ext_boot = s_d.st == ST_EXTBOOT;
    s_d.nr_run   = s_d.st == ST_ACTIVE;
    s_d.stats_on = s_d.st == ST_ACTIVE || s_d.st == ST_BYPASS;
    s_d.bypass   = s_d.st == ST_BYPASS && s_d.boot_p != PRESET_6;
    s_d.tone     = s_d.st == ST_BYPASS && s_d.boot_p == PRESET_6;
    s_d.analog   = s_d.st == ST_ACTIVE || s_d.st == ST_BYPASS;
    s_d.lowosc   = s_d.st == ST_SLEEP;

    case (s_d.boot_p)
      PRESET_3: begin s_d.tmin = 10'd50; s_d.tmax = 10'd500; end
      PRESET_4: begin s_d.tmin = 10'd5;  s_d.tmax = 10'd500; end
      PRESET_5: begin s_d.tmin = 10'd5;  s_d.tmax = 10'd100; end
      default:  begin s_d.tmin = 10'd0;  s_d.tmax = 10'd0;   end
    endcase

    s_d.int_osc = s_d.clk_p == PRESET_7;
    case (s_d.clk_p)
      PRESET_0: s_d.khz = 15'd2048;
      PRESET_3: s_d.khz = 15'd2400;
      PRESET_4: s_d.khz = 15'd2800;
      PRESET_5: s_d.khz = 15'd3072;
      PRESET_6: s_d.khz = 15'd26000;
      default:  s_d.khz = 15'd0;
    endcase

    case (s_d.chan_p)
      PRESET_3:
      begin
        s_d.diff = 1'b0; s_d.dual = 1'b1; s_d.ch0 = SRC_START; s_d.ch1 = SRC_MIXED;
      end
      PRESET_4:
      begin
        s_d.diff = 1'b0; s_d.dual = 1'b1; s_d.ch0 = SRC_MIXED; s_d.ch1 = SRC_END;
      end
      PRESET_5:
      begin
        s_d.diff = 1'b1; s_d.dual = 1'b0; s_d.ch0 = SRC_MIXED; s_d.ch1 = SRC_OFF;
      end
      PRESET_6:
      begin
        s_d.diff = 1'b0; s_d.dual = 1'b0; s_d.ch0 = SRC_MIXED; s_d.ch1 = SRC_OFF;
      end
      PRESET_7:
      begin
        s_d.diff = 1'b0; s_d.dual = 1'b0; s_d.ch0 = SRC_OFF; s_d.ch1 = SRC_MIXED;
      end
      default:
      begin
        s_d.diff = 1'b1; s_d.dual = 1'b0; s_d.ch0 = SRC_START; s_d.ch1 = SRC_OFF;
      end
    endcase

    case (s_d.mix_p)
      PRESET_3: s_d.mix = 7'd20;
      PRESET_4: s_d.mix = 7'd40;
      PRESET_5: s_d.mix = 7'd60;
      PRESET_6: s_d.mix = 7'd80;
      PRESET_7: s_d.mix = 7'd100;
      default:  s_d.mix = 7'd0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_q          <= '0;
      s_q.st       <= ST_RESET;
      s_q.resume   <= ST_ACTIVE;
      s_q.scl_prev <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign conv_start       = s_q.start;
  assign conv_sel         = s_q.sel;
  assign mode             = s_q.mode;
  assign config_done      = s_q.done;
  assign ext_boot         = s_q.ext_boot;
  assign nr_run           = s_q.nr_run;
  assign stats_on         = s_q.stats_on;
  assign bypass_route     = s_q.bypass;
  assign tone_on          = s_q.tone;
  assign analog_on        = s_q.analog;
  assign lowspeed_osc     = s_q.lowosc;
  assign talk_min_cm      = s_q.tmin;
  assign talk_max_cm      = s_q.tmax;
  assign external_clock_input_khz      = s_q.khz;
  assign int_osc          = s_q.int_osc;
  assign out_differential = s_q.diff;
  assign dual_outputs     = s_q.dual;
  assign ch0_src          = s_q.ch0;
  assign ch1_src          = s_q.ch1;
  assign mix_pct          = s_q.mix;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_top_band: assert property (
    s_q.st == ST_CONV && conv_done && s_q.sel == SEL_BOOT && conv_mv >= MV_EDGE_P0_P3
    |=> s_q.boot_p == PRESET_0) else $error("top band not preset 0");
  a_low_band: assert property (
    s_q.st == ST_CONV && conv_done && s_q.sel == SEL_MIX && conv_mv < MV_EDGE_P6_P7
    |=> s_q.mix_p == PRESET_7 ##0 s_q.mix == 7'd100) else $error("low band not preset 7");
  a_straps_frozen: assert property (
    s_q.done |=> $stable(s_q.boot_p) && $stable(s_q.clk_p) && $stable(s_q.chan_p))
    else $error("strap preset changed after boot");
  a_cmd_sleep_wake: assert property (
    s_q.st == ST_SLEEP && s_q.cmd_sleep && !scl_fall |=> s_q.st == ST_SLEEP)
    else $error("commanded sleep left without scl activity");
  a_loss_sleep: assert property (
    (s_q.st == ST_ACTIVE || s_q.st == ST_BYPASS) && clk_lost && !mode_cmd_valid
    |=> mode == MODE_SLEEP ##0 lowspeed_osc && !analog_on) else $error("no sleep on clock loss");
  a_standby_wake: assert property (
    s_q.st == ST_SLEEP && s_q.cmd_sleep && scl_fall |=> mode == MODE_STANDBY)
    else $error("scl wake did not reach standby");
  a_active_nr: assert property (
    mode == MODE_ACTIVE && !ext_boot && config_done |-> nr_run && stats_on && analog_on)
    else $error("active without processing");
  a_bypass_route: assert property (
    mode == MODE_BYPASS |-> stats_on && !nr_run && (bypass_route != tone_on))
    else $error("bypass routing wrong");
  a_cmd_bypass: assert property (
    (s_q.st == ST_ACTIVE || s_q.st == ST_STANDBY) && mode_cmd_valid && mode_cmd == CMD_BYPASS
    |=> mode == MODE_BYPASS) else $error("bypass command ignored");
  a_int_osc_no_loss: assert property (
    int_osc && s_q.st == ST_ACTIVE && !mode_cmd_valid |=> nr_run) else $error("int osc slept");

  c_boot_active: cover property (s_q.st == ST_CONV ##1 s_q.st == ST_ACTIVE);
  c_sleep_standby: cover property (mode == MODE_SLEEP ##[1:20] mode == MODE_STANDBY);
  c_standby_active: cover property (mode == MODE_STANDBY ##1 mode == MODE_ACTIVE);
  c_loss_resume: cover property (clk_lost ##[1:10] ext_edge && s_q.st == ST_SLEEP);

endmodule

// ==== dv/strap_converter_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// strap dividers behind the slow converter
// ----------------------------------------------------------------
module strap_converter_model (
  input  wire logic       clk,
  input  wire logic       conv_start,
  input  wire logic [1:0] conv_sel,
  input  wire logic [9:0] strap_mv [4],
  input  wire logic [3:0] lat,
  output logic            conv_done,
  output logic [9:0]      conv_mv
);
  logic [3:0] cnt_q = 4'h0;
  logic [1:0] sel_q = 2'h0;
  initial conv_done = 1'b0;
  initial conv_mv = 10'h000;
  // result valid only in the done cycle, else the bus keeps changing
  always @(posedge clk)
  begin
    conv_done <= 1'b0;
    conv_mv   <= ~conv_mv;
    if (conv_start && lat == 4'h0)
    begin
      conv_done <= 1'b1;
      conv_mv   <= strap_mv[conv_sel];
    end
    else if (conv_start)
    begin
      cnt_q <= lat;
      sel_q <= conv_sel;
    end
    else if (cnt_q == 4'h1)
    begin
      conv_done <= 1'b1;
      conv_mv   <= strap_mv[sel_q];
      cnt_q     <= 4'h0;
    end
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end
endmodule

// ==== dv/boot_config_mode_control_bench.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module boot_config_mode_control_bench;
  import boot_mode_pkg::*;
  localparam int SBY = 200;
  localparam int MV[8] = '{800, 800, 800, 560, 420, 280, 150, 30};
  localparam int KHZ[8] = '{2048, 2048, 2048, 2400, 2800, 3072, 26000, 0};
  localparam int TMIN[8] = '{0, 0, 0, 50, 5, 5, 0, 0};
  localparam int TMAX[8] = '{0, 0, 0, 500, 500, 100, 0, 0};
  localparam int PCT[8] = '{0, 0, 0, 20, 40, 60, 80, 100};
  localparam int C0[8] = '{0, 0, 0, 0, 1, 1, 1, 3};
  localparam int C1[8] = '{3, 3, 3, 1, 2, 3, 3, 1};
  localparam int L[6] = '{0, 3, 4, 5, 6, 7};
  int n_errors = 0;
  int n_checks = 0;
  logic clk = 1'b0, rstn = 1'b0, mode_cmd_valid = 1'b0, scl_level = 1'b1;
  logic external_clock_input = 1'b0, ext_run = 1'b1;
  logic [1:0] mode_cmd = 2'h0;
  logic [9:0] smv [4] = '{10'h000, 10'h000, 10'h000, 10'h000};
  logic [3:0] lat_q = 4'h0;
  logic conv_start, conv_done, config_done, ext_boot, nr_run, stats_on, bypass_route;
  logic tone_on, analog_on, lowspeed_osc, int_osc, out_differential, dual_outputs;
  logic [1:0] conv_sel, mode, ch0_src, ch1_src;
  logic [9:0] conv_mv, talk_min_cm, talk_max_cm;
  logic [14:0] external_clock_input_khz;
  logic [6:0] mix_pct;

  always #2 clk = ~clk;
  // stands still whenever the strap asks for the internal oscillator
  always @(posedge clk) if (ext_run) external_clock_input <= ~external_clock_input;

  boot_config_mode_control #(.STANDBY_TIMEOUT_CYC(SBY)) u_boot_config_mode_control (
    .clk, .rstn, .conv_start, .conv_sel, .conv_done, .conv_mv, .mode_cmd_valid,
    .mode_cmd, .scl_level, .external_clock_input, .mode, .config_done, .ext_boot,
    .nr_run, .stats_on, .bypass_route, .tone_on, .analog_on, .lowspeed_osc,
    .talk_min_cm, .talk_max_cm, .external_clock_input_khz, .int_osc, .out_differential,
    .dual_outputs, .ch0_src, .ch1_src, .mix_pct);
  strap_converter_model u_strap_converter_model (.clk, .conv_start, .conv_sel,
    .strap_mv(smv), .lat(lat_q), .conv_done, .conv_mv);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int pre(int v);
    return (v >= MV_EDGE_P0_P3) ? 0 : (v >= MV_EDGE_P3_P4) ? 3 : (v >= MV_EDGE_P4_P5) ? 4 :
           (v >= MV_EDGE_P5_P6) ? 5 : (v >= MV_EDGE_P6_P7) ? 6 : 7;
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmd(logic [1:0] c);
    @(posedge clk);
    mode_cmd_valid <= 1'b1;
    mode_cmd       <= c;
    @(posedge clk);
    mode_cmd_valid <= 1'b0;
    #1;
  endtask
  task automatic wait_mode(logic [1:0] m, int n);
    for (int i = 0; i < n && mode !== m; i++) cyc(1);
  endtask
  task automatic scl_pulse;
    @(posedge clk);
    scl_level <= 1'b0;
    repeat (2) @(posedge clk);
    scl_level <= 1'b1;
    #1;
  endtask
  task automatic boot(int b, int c, int h, int m, logic [3:0] lt);
    int pb, pc, ph, pm;
    pb = pre(b); pc = pre(c); ph = pre(h); pm = pre(m);
    @(posedge clk);
    rstn  <= 1'b0;
    smv   <= '{10'(b), 10'(c), 10'(h), 10'(m)};
    lat_q <= lt;
    ext_run <= (pc != 7);
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 300 && config_done !== 1'b1; i++) cyc(1);
    `CHK(config_done, 1'b1)
    `CHK(ext_boot, pb == 0)
    `CHK(mode, (pb >= 6) ? MODE_BYPASS : MODE_ACTIVE)
    `CHK(nr_run, pb inside {[3:5]})
    `CHK(stats_on, pb != 0)
    `CHK(analog_on, pb != 0)
    `CHK(tone_on, pb == 6)
    `CHK(bypass_route, pb == 7)
    `CHK(talk_min_cm, 10'(TMIN[pb]))
    `CHK(talk_max_cm, 10'(TMAX[pb]))
    `CHK(external_clock_input_khz, 15'(KHZ[pc]))
    `CHK(int_osc, pc == 7)
    `CHK(out_differential, ph == 0 || ph == 5)
    `CHK(dual_outputs, ph == 3 || ph == 4)
    `CHK(ch0_src, 2'(C0[ph]))
    `CHK(ch1_src, 2'(C1[ph]))
    `CHK(mix_pct, 7'(PCT[pm]))
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_presets;
    for (int i = 0; i < 6; i++)
      boot(MV[L[i]], MV[L[(i+1)%6]], MV[L[(i+2)%6]], MV[L[(i+3)%6]], 4'((i % 2) * 4));
    boot(640, 639, 494, 75, 4'h1);
    boot(1000, 356, 74, 355, 4'h2);
  endtask
  task automatic t_modes;
    boot(560, 800, 800, 800, 4'h2);
    cmd(2'h3);
    `CHK(mode, MODE_ACTIVE)
    cmd(CMD_BYPASS);
    `CHK(mode, MODE_BYPASS)
    `CHK(bypass_route, 1'b1)
    `CHK(nr_run, 1'b0)
    `CHK(stats_on, 1'b1)
    cmd(CMD_ACTIVE);
    `CHK(mode, MODE_ACTIVE)
    `CHK(nr_run, 1'b1)
    cmd(CMD_SLEEP);
    `CHK(mode, MODE_SLEEP)
    `CHK(analog_on, 1'b0)
    `CHK(lowspeed_osc, 1'b1)
    `CHK(nr_run, 1'b0)
    cmd(CMD_ACTIVE);
    `CHK(mode, MODE_SLEEP)
    ext_run <= 1'b0;
    cyc(3000);
    `CHK(mode, MODE_SLEEP)
    ext_run <= 1'b1;
    scl_pulse();
    wait_mode(MODE_STANDBY, 8);
    `CHK(mode, MODE_STANDBY)
    cyc(20);
    cmd(CMD_ACTIVE);
    `CHK(mode, MODE_ACTIVE)
    cmd(CMD_SLEEP);
    scl_pulse();
    wait_mode(MODE_STANDBY, 8);
    cyc(SBY - 3);
    `CHK(mode, MODE_STANDBY)
    cyc(2);
    `CHK(mode, MODE_SLEEP)
    scl_pulse();
    wait_mode(MODE_STANDBY, 8);
    `CHK(mode, MODE_STANDBY)
    cmd(CMD_BYPASS);
    `CHK(mode, MODE_BYPASS)
  endtask
  task automatic t_clock_loss;
    ext_run <= 1'b0;
    cyc(2400);
    `CHK(mode, MODE_BYPASS)
    wait_mode(MODE_SLEEP, 200);
    `CHK(mode, MODE_SLEEP)
    `CHK(lowspeed_osc, 1'b1)
    scl_pulse();
    cyc(5);
    `CHK(mode, MODE_SLEEP)
    ext_run <= 1'b1;
    wait_mode(MODE_BYPASS, 10);
    `CHK(mode, MODE_BYPASS)
  endtask
  task automatic t_internal_osc;
    boot(560, 30, 420, 150, 4'h3);
    cyc(3000);
    `CHK(mode, MODE_ACTIVE)
    smv <= '{10'd800, 10'd800, 10'd800, 10'd800};
    cyc(50);
    `CHK(external_clock_input_khz, 15'h0000)
    `CHK(talk_min_cm, 10'd50)
    `CHK(mix_pct, 7'd80)
  endtask

  task automatic final_report;
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #(4 * 60000);
    n_errors++;
    final_report();
  end
  initial
  begin
    t_presets();
    t_modes();
    t_clock_loss();
    t_internal_osc();
    final_report();
  end
endmodule
